// >>> rtl/bpcmd_pkg.sv
// Constants for the primary command register block of the bridge.
// Assumes a dword-indexed configuration access port and one core clock.
package bpcmd_pkg;

  // Configuration offset (byte) and its dword index
  localparam logic [11:0] BPCMD_CMD_OFF     = 12'h004;
  localparam logic [9:0]  BPCMD_CMD_IDX     = 10'h001;

  // Command bit positions
  localparam int          BPCMD_IO_EN       = 0;
  localparam int          BPCMD_MEM_EN      = 1;
  localparam int          BPCMD_BM_EN       = 2;
  localparam int          BPCMD_SPC_EN      = 3;
  localparam int          BPCMD_MWI_EN      = 4;
  localparam int          BPCMD_VGA_EN      = 5;
  localparam int          BPCMD_PERR_EN     = 6;
  localparam int          BPCMD_WAIT_EN     = 7;
  localparam int          BPCMD_SERR_EN     = 8;
  localparam int          BPCMD_FBB_EN      = 9;
  localparam int          BPCMD_INT_DIS     = 10;

  // Status bit for master data parity error, within the dword
  localparam int          BPCMD_MDPE_BIT    = 24;

  // Values after reset
  localparam logic [15:0] BPCMD_CMD_RESET   = 16'h0000;
  localparam logic        BPCMD_MDPE_RESET  = 1'h0;

  // Writable command bits per mode; all others read zero
  localparam logic [15:0] BPCMD_RW_MASK_FWD = 16'h0147;
  localparam logic [15:0] BPCMD_RW_MASK_REV = 16'h0567;

  // VGA palette I/O addresses, low ten bits only
  localparam logic [9:0]  BPCMD_VGA_A0      = 10'h3c6;
  localparam logic [9:0]  BPCMD_VGA_A1      = 10'h3c8;
  localparam logic [9:0]  BPCMD_VGA_A2      = 10'h3c9;

  // Depth of the pin synchroniser
  localparam int          BPCMD_SYNC_LEN    = 3;

endpackage : bpcmd_pkg

// >>> rtl/bpcmd_top.sv
// Primary command register of the bridge, with the gating it applies to
// primary and secondary traffic, error signalling and legacy interrupts.
// Assumes the configuration port and request strobes share ref_clk_i, and
// that the mode straps arrive from pins outside that clock domain.
`timescale 1ns/10ps

module bpcmd_top
  import bpcmd_pkg::*;
(
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  input  wire logic        cfg_wr_i,
  input  wire logic        cfg_rd_i,
  input  wire logic [9:0]  cfg_addr_i,
  input  wire logic [3:0]  cfg_be_i,
  input  wire logic [31:0] cfg_wdata_i,
  input  wire logic        reverse_mode_i,
  input  wire logic        pcix_mode_i,
  input  wire logic        io_req_i,
  input  wire logic        io_wr_i,
  input  wire logic [9:0]  io_addr_i,
  input  wire logic        mem_req_i,
  input  wire logic        sec_req_i,
  input  wire logic        fwd_req_i,
  input  wire logic        split_req_i,
  input  wire logic        par_evt_i,
  input  wire logic        err_evt_i,
  input  wire logic [3:0]  intx_req_i,
  output logic      [31:0] cfg_rdata_o,
  output logic             cfg_rvalid_o,
  output logic             io_claim_o,
  output logic             mem_claim_o,
  output logic             sec_claim_o,
  output logic             master_go_o,
  output logic             split_go_o,
  output logic             err_msg_o,
  output logic             serr_o,
  output logic      [3:0]  intx_assert_o,
  output logic             mdpe_o
);

  // Pin synchronisers: [0] reverse mode, [1] PCI-X mode
  logic [1:0] pin_in;
  logic [1:0] pin_s1_r;
  logic [1:0] pin_s2_r;
  logic [1:0] pin_s3_r;
  logic [1:0] pin_val_r;

  assign pin_in = {pcix_mode_i, reverse_mode_i};

  // Three stages; a level counts only once stages two and three agree
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_sync
      always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
          pin_s1_r[g]  <= 1'h0;
          pin_s2_r[g]  <= 1'h0;
          pin_s3_r[g]  <= 1'h0;
          pin_val_r[g] <= 1'h0;
        end else begin
          pin_s1_r[g] <= pin_in[g];
          pin_s2_r[g] <= pin_s1_r[g];
          pin_s3_r[g] <= pin_s2_r[g];
          if (pin_s2_r[g] == pin_s3_r[g]) begin
            pin_val_r[g] <= pin_s3_r[g];
          end
        end
      end
    end
  endgenerate

  wire rev_mode  = pin_val_r[0];
  wire pcix_mode = pin_val_r[1];

  // Writable mask per mode; the reverse-only bits vanish in forward mode
  function automatic logic [15:0] rw_mask(input logic rev);
    rw_mask = rev ? BPCMD_RW_MASK_REV : BPCMD_RW_MASK_FWD;
  endfunction : rw_mask

  // VGA palette address match on low ten bits, upper bits are don't-care
  function automatic logic vga_addr(input logic [9:0] a);
    vga_addr = (a == BPCMD_VGA_A0) || (a == BPCMD_VGA_A1) || (a == BPCMD_VGA_A2);
  endfunction : vga_addr

  logic [15:0] cmd_r;
  logic [15:0] cmd_nxt;
  logic        mdpe_r;
  logic        mdpe_nxt;

  // Command view: read-only and reserved bits always zero
  wire [15:0] cmd_view = cmd_r & rw_mask(rev_mode);

  // Register decode
  wire hit     = (cfg_addr_i == BPCMD_CMD_IDX);
  wire wr_hit  = cfg_wr_i && hit;
  wire [15:0] wr_bytes = {{8{cfg_be_i[1]}}, {8{cfg_be_i[0]}}};
  wire [15:0] wr_merge = (cfg_wdata_i[15:0] & wr_bytes) | (cmd_view & ~wr_bytes);

  // Only RW bits take the written value
  assign cmd_nxt = wr_hit ? (wr_merge & rw_mask(rev_mode)) : cmd_view;

  // Parity flag: a fresh event wins over a same-cycle write-one clear
  wire mdpe_set = par_evt_i && cmd_view[BPCMD_PERR_EN];
  wire mdpe_clr = wr_hit && cfg_be_i[3] && cfg_wdata_i[BPCMD_MDPE_BIT];
  assign mdpe_nxt = mdpe_set || (mdpe_r && !mdpe_clr);

  // Register state
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cmd_r  <= BPCMD_CMD_RESET;
      mdpe_r <= BPCMD_MDPE_RESET;
    end else begin
      cmd_r  <= cmd_nxt;
      mdpe_r <= mdpe_nxt;
    end
  end

  // Read data: command low, parity flag at its status position, rest zero
  wire [31:0] rd_word = hit ? {7'h00, mdpe_r, 8'h00, cmd_view} : 32'h0000_0000;

  // Traffic gating, decoded here and registered so outputs come from flops
  wire vga_hit     = rev_mode && cmd_view[BPCMD_VGA_EN] && io_req_i && io_wr_i
                     && vga_addr(io_addr_i);
  wire io_claim_d  = (io_req_i && cmd_view[BPCMD_IO_EN]) || vga_hit;
  wire mem_claim_d = mem_req_i && cmd_view[BPCMD_MEM_EN];
  wire sec_claim_d = sec_req_i && cmd_view[BPCMD_BM_EN];
  wire master_d    = fwd_req_i && cmd_view[BPCMD_BM_EN];
  // Split completions answer requests already accepted, so a PCI-X
  // reverse primary may not strand them behind a cleared master enable
  wire split_d     = split_req_i && (cmd_view[BPCMD_BM_EN]
                     || (rev_mode && pcix_mode));
  wire err_msg_d   = err_evt_i && !rev_mode && cmd_view[BPCMD_SERR_EN];
  wire serr_d      = err_evt_i && rev_mode && cmd_view[BPCMD_SERR_EN];
  wire int_block   = rev_mode && cmd_view[BPCMD_INT_DIS];
  wire [3:0] intx_d = intx_req_i & {4{!int_block}};

  // Output flops
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cfg_rdata_o   <= 32'h0000_0000;
      cfg_rvalid_o  <= 1'h0;
      io_claim_o    <= 1'h0;
      mem_claim_o   <= 1'h0;
      sec_claim_o   <= 1'h0;
      master_go_o   <= 1'h0;
      split_go_o    <= 1'h0;
      err_msg_o     <= 1'h0;
      serr_o        <= 1'h0;
      intx_assert_o <= 4'h0;
      mdpe_o        <= 1'h0;
    end else begin
      cfg_rdata_o   <= cfg_rd_i ? rd_word : 32'h0000_0000;
      cfg_rvalid_o  <= cfg_rd_i;
      io_claim_o    <= io_claim_d;
      mem_claim_o   <= mem_claim_d;
      sec_claim_o   <= sec_claim_d;
      master_go_o   <= master_d;
      split_go_o    <= split_d;
      err_msg_o     <= err_msg_d;
      serr_o        <= serr_d;
      intx_assert_o <= intx_d;
      mdpe_o        <= mdpe_nxt;
    end
  end

  // Checks on the gating and register behaviour
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  a_io_ignored: assert property (
    (io_req_i && !cmd_view[BPCMD_IO_EN] && !vga_hit) |=> !io_claim_o)
    else $error("I/O claimed while I/O decode disabled");

  a_mem_gating: assert property (
    mem_req_i |=> (mem_claim_o == $past(cmd_view[BPCMD_MEM_EN])))
    else $error("Memory claim does not follow memory enable");

  a_master_gate: assert property (
    (!cmd_view[BPCMD_BM_EN]) |=> (!master_go_o && !sec_claim_o))
    else $error("Mastering or secondary claim with master enable clear");

  a_split_pcix: assert property (
    (split_req_i && rev_mode && pcix_mode) |=> split_go_o)
    else $error("Split completion blocked on reverse PCI-X primary");

  a_ro_zero: assert property (
    (cfg_rvalid_o && $past(hit)) |-> (cfg_rdata_o[15:11] == 5'h00
      && cfg_rdata_o[BPCMD_SPC_EN] == 1'h0 && cfg_rdata_o[BPCMD_MWI_EN] == 1'h0
      && cfg_rdata_o[BPCMD_WAIT_EN] == 1'h0 && cfg_rdata_o[BPCMD_FBB_EN] == 1'h0))
    else $error("Read-only or reserved command bit read as one");

  a_vga_decode: assert property (
    (rev_mode && cmd_view[BPCMD_VGA_EN] && io_req_i && io_wr_i
      && io_addr_i == BPCMD_VGA_A1) |=> io_claim_o)
    else $error("VGA palette write not claimed");

  a_mdpe_set: assert property (
    (par_evt_i && cmd_view[BPCMD_PERR_EN]) |=> mdpe_r ##0 mdpe_o)
    else $error("Parity flag not set after qualifying event");

  a_mdpe_hold: assert property (
    (!mdpe_r && !cmd_view[BPCMD_PERR_EN]) |=> !mdpe_r)
    else $error("Parity flag set while response disabled");

  a_serr_mode: assert property (
    (err_evt_i && cmd_view[BPCMD_SERR_EN]) |=> (serr_o != err_msg_o))
    else $error("Error report went to wrong path or nowhere");

  a_int_block: assert property (
    (rev_mode && cmd_view[BPCMD_INT_DIS]) |=> (intx_assert_o == 4'h0))
    else $error("Legacy interrupt asserted while disabled");

  a_fwd_rev_bits: assert property (
    !rev_mode |=> (cmd_r[BPCMD_VGA_EN] == 1'h0 && cmd_r[BPCMD_INT_DIS] == 1'h0))
    else $error("Reverse-only bit stored in forward mode");

  // Enabled requests must be claimed, not only refused ones blocked
  a_io_claim: assert property (
    (io_req_i && cmd_view[BPCMD_IO_EN]) |=> io_claim_o)
    else $error("Enabled I/O request not claimed");

  a_cmd_write: assert property (
    (wr_hit && cfg_be_i[0]) |=> (cmd_r[BPCMD_IO_EN] == $past(cfg_wdata_i[BPCMD_IO_EN])))
    else $error("Written I/O enable not stored");

  a_mem_idle: assert property (
    !mem_req_i |=> !mem_claim_o)
    else $error("Memory claim without a request");

  a_sec_claim: assert property (
    (sec_req_i && cmd_view[BPCMD_BM_EN]) |=> sec_claim_o)
    else $error("Enabled secondary request not claimed");

  a_master_go: assert property (
    (fwd_req_i && cmd_view[BPCMD_BM_EN]) |=> master_go_o)
    else $error("Enabled forwarded request not mastered");

  a_split_block: assert property (
    (split_req_i && !cmd_view[BPCMD_BM_EN] && !(rev_mode && pcix_mode)) |=> !split_go_o)
    else $error("Split completion started with master enable clear");

  a_err_gate: assert property (
    (!err_evt_i || !cmd_view[BPCMD_SERR_EN]) |=> (!err_msg_o && !serr_o))
    else $error("Error reported without event or enable");

  a_int_pass: assert property (
    !(rev_mode && cmd_view[BPCMD_INT_DIS]) |=> (intx_assert_o == $past(intx_req_i)))
    else $error("Legacy interrupt lines not passed while allowed");

  // Hard-wired bits must not take a written one; the flag sticks until cleared
  a_spc_zero: assert property (
    (wr_hit && cfg_be_i[0]) |=> !cmd_r[BPCMD_SPC_EN])
    else $error("Special cycle bit took a write");

  a_mwi_zero: assert property (
    (wr_hit && cfg_be_i[0]) |=> !cmd_r[BPCMD_MWI_EN])
    else $error("Write and invalidate bit took a write");

  a_wait_zero: assert property (
    (wr_hit && cfg_be_i[0]) |=> !cmd_r[BPCMD_WAIT_EN])
    else $error("Wait cycle bit took a write");

  a_fbb_zero: assert property (
    (wr_hit && cfg_be_i[1]) |=> !cmd_r[BPCMD_FBB_EN])
    else $error("Back-to-back bit took a write");

  a_rsvd_zero: assert property (
    (wr_hit && cfg_be_i[1]) |=> (cmd_r[15:11] == 5'h00))
    else $error("Reserved command bits took a write");

  a_mdpe_clear: assert property (
    (mdpe_clr && !(par_evt_i && cmd_view[BPCMD_PERR_EN])) |=> !mdpe_r)
    else $error("Parity flag not cleared by write of one");

  a_mdpe_sticky: assert property (
    (mdpe_r && !mdpe_clr) |=> mdpe_r)
    else $error("Parity flag dropped without a clear");

  a_rd_status: assert property (
    (cfg_rd_i && hit) |=> (cfg_rdata_o[BPCMD_MDPE_BIT] == $past(mdpe_r)))
    else $error("Read data does not show the parity flag");

  c_write_io_en: cover property (
    wr_hit && cfg_be_i[0] && cfg_wdata_i[BPCMD_IO_EN] ##1 io_req_i ##1 io_claim_o);
  c_mdpe_clear: cover property (mdpe_r ##1 mdpe_clr ##1 !mdpe_r);
  c_vga_claim: cover property (vga_hit ##1 io_claim_o);
  c_split_no_bm: cover property (split_go_o && !cmd_view[BPCMD_BM_EN]);
  c_int_blocked: cover property (rev_mode && cmd_view[BPCMD_INT_DIS] && (intx_req_i != 4'h0));

endmodule : bpcmd_top

// >>> test/bpcmd_far_model.sv
// Far-side traffic source: random primary and secondary requests.
// Assumes the bench samples the pins before each falling-edge update.
`timescale 1ns/10ps
module bpcmd_far_model (
  input  wire logic       ref_clk_i,
  input  wire logic       en_i,
  output logic      [7:0] req_o,
  output logic      [9:0] io_addr_o,
  output logic      [3:0] intx_o
);
  // Requests change on falling edges; the address leans on the palette slots
  // and keeps moving while idle so a stale value is never mistaken for a hit
  always @(negedge ref_clk_i) begin
    req_o     <= en_i ? 8'($urandom) : 8'h00;
    intx_o    <= en_i ? 4'($urandom) : 4'h0;
    io_addr_o <= ($urandom_range(3) == 0) ? 10'($urandom) : 10'h3c6 + 10'($urandom_range(3));
  end
endmodule : bpcmd_far_model

// >>> test/tb_bpcmd_top.sv
// Bench for the primary command register: config access and traffic gating.
// Assumes straps settle within six cycles and the far model drives traffic.
`timescale 1ns/10ps
module tb_bpcmd_top;
  import bpcmd_pkg::*;
  logic        ref_clk_i, rst_i, cfg_wr_i, cfg_rd_i, rev, pcix, en, e_mdpe;
  logic [9:0]  cfg_addr_i, io_addr;
  logic [3:0]  cfg_be_i, intx_req, intx_o;
  logic [31:0] cfg_wdata_i, cfg_rdata_o;
  logic [7:0]  req;
  logic        rvalid, io_c, mem_c, sec_c, mg, sg, em, se, mdpe;
  logic [15:0] cw, c, mask;
  int          bad_count, tests_run, m, k;
  assign mask = rev ? BPCMD_RW_MASK_REV : BPCMD_RW_MASK_FWD;
  bpcmd_top bpcmd_top_inst (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .cfg_wr_i(cfg_wr_i),
    .cfg_rd_i(cfg_rd_i), .cfg_addr_i(cfg_addr_i), .cfg_be_i(cfg_be_i),
    .cfg_wdata_i(cfg_wdata_i), .reverse_mode_i(rev), .pcix_mode_i(pcix), .io_req_i(req[0]),
    .io_wr_i(req[1]), .io_addr_i(io_addr), .mem_req_i(req[2]), .sec_req_i(req[3]),
    .fwd_req_i(req[4]), .split_req_i(req[5]), .par_evt_i(req[6]), .err_evt_i(req[7]),
    .intx_req_i(intx_req), .cfg_rdata_o(cfg_rdata_o), .cfg_rvalid_o(rvalid),
    .io_claim_o(io_c), .mem_claim_o(mem_c), .sec_claim_o(sec_c), .master_go_o(mg),
    .split_go_o(sg), .err_msg_o(em), .serr_o(se), .intx_assert_o(intx_o), .mdpe_o(mdpe));
  bpcmd_far_model bpcmd_far_model_inst (.ref_clk_i(ref_clk_i), .en_i(en), .req_o(req),
    .io_addr_o(io_addr), .intx_o(intx_req));
  // Expected gated outputs from the pins sampled at the last rising edge
  function automatic logic [10:0] exp_trf(input logic [15:0] v);
    logic vga;
    vga = rev & v[BPCMD_VGA_EN] & req[1]
          & (io_addr inside {BPCMD_VGA_A0, BPCMD_VGA_A1, BPCMD_VGA_A2});
    return {req[0] & (v[0] | vga), req[2] & v[1], req[3] & v[2], req[4] & v[2],
            req[5] & (v[2] | (rev & pcix)), req[7] & v[8] & !rev, req[7] & v[8] & rev,
            (rev & v[10]) ? 4'h0 : intx_req};
  endfunction : exp_trf
  task automatic chk_reg(input logic [32:0] exp, input logic [32:0] got);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH cfg_read expected %h seen %h", exp, got);
    end
  endtask : chk_reg
  task automatic chk_trf(input logic [11:0] exp, input logic [11:0] got);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH traffic expected %h seen %h", exp, got);
    end
  endtask : chk_trf
  task automatic cfg_wr(input logic [9:0] a, input logic [3:0] be, input logic [31:0] d);
    @(negedge ref_clk_i);
    cfg_wr_i    = 1'b1;
    cfg_addr_i  = a;
    cfg_be_i    = be;
    cfg_wdata_i = d;
    @(negedge ref_clk_i);
    cfg_wr_i = 1'b0;
  endtask : cfg_wr
  // Read answer stands one cycle, so it is looked at on the next falling edge
  task automatic cfg_rd(input logic [9:0] a, input logic [31:0] exp);
    @(negedge ref_clk_i);
    cfg_rd_i   = 1'b1;
    cfg_addr_i = a;
    @(negedge ref_clk_i);
    cfg_rd_i = 1'b0;
    chk_reg({1'b1, exp}, {rvalid, cfg_rdata_o});
  endtask : cfg_rd
  task automatic step();
    logic [11:0] got;
    @(negedge ref_clk_i);
    got    = {io_c, mem_c, sec_c, mg, sg, em, se, intx_o, mdpe};
    e_mdpe = e_mdpe | (req[6] & c[BPCMD_PERR_EN]);
    chk_trf({exp_trf(c), e_mdpe}, got);
  endtask : step
  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : close_out
  initial begin
    ref_clk_i = 1'b0;
    forever #2 ref_clk_i = ~ref_clk_i;
  end
  // Watchdog well past the roughly one thousand cycles the tests need
  initial begin
    #50000;
    bad_count++;
    close_out();
  end
  initial begin
    {cfg_wr_i, cfg_rd_i, rev, pcix, en, e_mdpe} = '0;
    {cfg_addr_i, cfg_be_i, cfg_wdata_i} = '0;
    {bad_count, tests_run} = '0;
    c     = 16'h0000;
    rst_i = 1'b1;
    void'($urandom(18));
    repeat (6) @(negedge ref_clk_i);
    rst_i = 1'b0;
    cfg_rd(BPCMD_CMD_IDX, 32'h0);
    cfg_wr(BPCMD_CMD_IDX, 4'h1, 32'hffff_ffff);
    cfg_wr(10'h002, 4'hf, 32'hffff_ffff);
    cfg_rd(10'h002, 32'h0);
    cfg_rd(BPCMD_CMD_IDX, 32'h0000_0047);
    c = 16'h0047;
    // Forward, reverse PCI, reverse PCI-X, then forward again to see masking
    for (m = 0; m < 4; m++) begin
      rev  = (m == 1) || (m == 2);
      pcix = (m >= 2);
      repeat (6) @(negedge ref_clk_i);
      // The stored value was masked in the old mode, so mask what is held
      c = c & mask;
      cfg_rd(BPCMD_CMD_IDX, {16'h0, c});
      for (k = 0; k < 5; k++) begin
        cw = (k == 0) ? 16'hffff : 16'($urandom);
        cfg_wr(BPCMD_CMD_IDX, 4'h3, {16'h0, cw});
        c = cw & mask;
        cfg_rd(BPCMD_CMD_IDX, {16'h0, c});
        en <= 1'b1;
        repeat (30) step();
        en <= 1'b0;
        step();
        step();
        cfg_rd(BPCMD_CMD_IDX, {7'h0, e_mdpe, 8'h0, c});
        cfg_wr(BPCMD_CMD_IDX, 4'h8, 32'h0100_0000);
        e_mdpe = 1'b0;
      end
    end
    // A reset in mid-run must drop a fully written command back to zero
    cfg_wr(BPCMD_CMD_IDX, 4'h3, 32'h0000_ffff);
    rst_i = 1'b1;
    repeat (2) @(negedge ref_clk_i);
    rst_i = 1'b0;
    c = 16'h0000;
    cfg_rd(BPCMD_CMD_IDX, 32'h0);
    en <= 1'b1;
    repeat (10) step();
    en <= 1'b0;
    step();
    step();
    close_out();
  end
endmodule : tb_bpcmd_top
